/* File: verilog/ee_slave.sv */
// two-wire serial eeprom slave: protocol engine, page buffer, timed commit
// assumes scl/sda/wp/chip selects are asynchronous pins; sda is open drain
`timescale 1ns/1ps
`default_nettype none
// Operation
// - sda fall while scl high is start
// - sda rise while scl high is stop
// - one bit per clock, sampled high
// - receiver acks every byte on ninth clock
// - no acks while programming cycle runs
// - ack holds sda low whole high phase
// - master nack ends read, sda released
// - control byte: code, selects, read/write
// - ack control only on code and select match
// - last control bit: one read, zero write
// - byte write acks control, addresses, data
// - stop after data launches timed write
// - page buffer holds 32 bytes until stop
// - only five low pointer bits increment
// - page crossing wraps within same page
// - over 32 bytes overwrite buffered bytes
// - polling control byte acked once idle
// - pointer holds last address plus one
// - read control acked, byte shifted out
// - address write sets pointer before restart
// - idle bus has both lines high
// - sequential read wraps top to zero
// - write protect blocks all memory writes
module ee_slave import ee_pkg::*; #(
	parameter int         WR_CYCLES = TWR_CYC,
	parameter logic [3:0] TYPE_CODE = 4'h5  // arbitrary device-type value
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// two-wire bus
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      sda_val,
	output logic      sda_oe,
	// straps and status
	input  wire logic write_protect,
	input  wire logic chip_select_pin_low,
	input  wire logic chip_select_pin_mid,
	input  wire logic chip_select_pin_high,
	output logic      busy
);
	// pin synchronisers: first stage feeds only the second
	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic       scl_d1_q;
	logic       sda_d1_q;

	always_ff @(posedge sys_clk) begin
		meta_q <= {write_protect, chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low, scl_line, sda_line};
		sync_q <= meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= sync_q[1];
			sda_d1_q <= sync_q[0];
		end
	end

	wire       sda_s = sync_q[0];
	wire       scl_s = sync_q[1];
	wire [2:0] cs_s  = sync_q[4:2];
	wire       wp_s  = sync_q[5];

	// bus conditions
	wire scl_rise  = scl_s && !scl_d1_q;
	wire scl_fall  = !scl_s && scl_d1_q;
	wire start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
	wire stop_det  = scl_s && scl_d1_q && !sda_d1_q && sda_s;

	// engine state
	ee_state_e            state_q;
	logic [3:0]           bit_cnt_q;
	logic                 in_ack_q;
	logic [7:0]           shreg_q;
	logic [7:0]           tx_q;
	logic [ADDR_W-1:0]    ptr_q;
	logic                 drive_q;
	logic                 ack_q;
	logic                 mack_q;
	logic                 dirty_q;
	logic                 commit_req_q;
	logic [4:0]           hold_q;
	logic                 sda_oe_q;
	logic                 sda_o_q;
	logic                 busy_q;
	logic [31:0]          wr_cnt_q;
	logic [7:0]           mem_q [MEM_DEPTH];
	logic [7:0]           pbuf_q [PAGE_SIZE];
	logic [PAGE_SIZE-1:0] pvld_q;
	logic [ADDR_W-PAGE_W-1:0] page_q;

	// byte-level decode
	wire rx_mode   = (state_q != ST_IDLE) && (state_q != ST_RDATA) && (state_q != ST_SKIP);
	wire byte_done = rx_mode && scl_fall && !in_ack_q && (bit_cnt_q == BIT_FULL);
	wire ctrl_ok   = (shreg_q[CTRL_ID_MSB:CTRL_ID_LSB] == TYPE_CODE)
	              && (shreg_q[CTRL_CS_MSB:CTRL_CS_LSB] == cs_s);
	wire is_read   = shreg_q[CTRL_RW_BIT];
	wire idle_ok   = !busy_q && !commit_req_q;
	wire fifo_rdy;
	wire ack_ctrl  = ctrl_ok && idle_ok;
	wire ack_data  = fifo_rdy;
	wire do_ack    = (state_q == ST_CTRL) ? ack_ctrl :
	                 (state_q == ST_WDATA) ? ack_data : 1'b1;
	wire wr_push   = byte_done && (state_q == ST_WDATA) && fifo_rdy;
	wire [ADDR_W-1:0] ptr_page_inc = {ptr_q[ADDR_W-1:PAGE_W], ptr_q[PAGE_W-1:0] + 5'h01};
	wire [ADDR_W-1:0] ptr_lin_inc  = ptr_q + 12'h001;
	wire tx_end    = (state_q == ST_RDATA) && scl_fall && !in_ack_q && (bit_cnt_q == BIT_FULL);
	wire tx_shift  = (state_q == ST_RDATA) && scl_fall && !in_ack_q && (bit_cnt_q != BIT_FULL);
	wire ack_end   = scl_fall && in_ack_q;
	wire go_read   = ack_end && ((state_q == ST_RDATA) ? mack_q : 1'b0);

	// write byte buffer between engine and page buffer
	ee_wr_s wr_in;
	ee_wr_s wr_out;
	wire    wr_out_valid;
	wire    wr_out_ready = !busy_q;
	assign wr_in = '{addr: ptr_q, data: shreg_q};

	ee_fifo2 #(
		.W ($bits(ee_wr_s))
	) ee_fifo2_i (
		.clk       (sys_clk),
		.rst       (sys_rst),
		.in_valid  (wr_push),
		.in_ready  (fifo_rdy),
		.in_data   (wr_in),
		.out_valid (wr_out_valid),
		.out_ready (wr_out_ready),
		.out_data  (wr_out)
	);

	// protocol state machine
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			bit_cnt_q <= BIT_ZERO;
			in_ack_q  <= 1'b0;
			ack_q     <= 1'b0;
			mack_q    <= 1'b0;
		end else if (start_det) begin
			state_q   <= ST_CTRL;
			bit_cnt_q <= BIT_ZERO;
			in_ack_q  <= 1'b0;
			ack_q     <= 1'b0;
		end else if (stop_det) begin
			state_q   <= ST_IDLE;
			bit_cnt_q <= BIT_ZERO;
			in_ack_q  <= 1'b0;
			ack_q     <= 1'b0;
		end else if (byte_done) begin
			in_ack_q <= 1'b1;
			ack_q    <= do_ack;
			case (state_q)
				ST_CTRL:  state_q <= !ack_ctrl ? ST_SKIP : (is_read ? ST_RDATA : ST_ADRH);
				ST_ADRH:  state_q <= ST_ADRL;
				ST_ADRL:  state_q <= ST_WDATA;
				default:  state_q <= state_q;
			endcase
		end else if (tx_end) begin
			in_ack_q <= 1'b1;
		end else if (ack_end) begin
			in_ack_q  <= 1'b0;
			ack_q     <= 1'b0;
			bit_cnt_q <= BIT_ZERO;
			if ((state_q == ST_RDATA) && !mack_q && bit_cnt_q == BIT_FULL)
				state_q <= ST_SKIP;
		end else if (scl_rise && !in_ack_q && state_q != ST_IDLE && state_q != ST_SKIP) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (scl_rise && in_ack_q) begin
			mack_q <= !sda_s;
		end
	end

	// receive shifter samples on the rising edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			shreg_q <= 8'h00;
		else if (scl_rise && !in_ack_q && rx_mode)
			shreg_q <= {shreg_q[6:0], sda_s};
	end

	// address pointer
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ptr_q <= 12'h000;
		else if (byte_done && state_q == ST_ADRH)
			ptr_q[ADDR_W-1:BYTE_BITS] <= shreg_q[ADDR_HI_BITS-1:0];
		else if (byte_done && state_q == ST_ADRL)
			ptr_q[BYTE_BITS-1:0] <= shreg_q;
		else if (wr_push)
			ptr_q <= ptr_page_inc;
		else if ((ack_end && state_q == ST_CTRL && ack_ctrl && is_read) || go_read)
			ptr_q <= ptr_lin_inc;
	end

	// transmit shifter loads on the falling edge that ends an ack slot
	wire tx_load = ack_end && ((state_q == ST_RDATA && bit_cnt_q == BIT_ZERO) || go_read);

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			tx_q <= 8'hFF;
		else if (tx_load)
			tx_q <= mem_q[ptr_q];
		else if (tx_shift)
			tx_q <= {tx_q[6:0], 1'b1};
	end

	// desired pull-down; a read byte starts on the fall that ends the ack slot
	wire read_first = ack_end && state_q == ST_RDATA && (bit_cnt_q == BIT_ZERO || mack_q);
	wire [7:0] tx_next = mem_q[ptr_q];

	always_ff @(posedge sys_clk) begin
		if (sys_rst || start_det || stop_det)
			drive_q <= 1'b0;
		else if (byte_done)
			drive_q <= do_ack;
		else if (read_first)
			drive_q <= !tx_next[BYTE_BITS-1];
		else if (tx_shift)
			drive_q <= !tx_q[BYTE_BITS-2];
		else if (tx_end || ack_end)
			drive_q <= 1'b0;
	end

	// hold data after scl falls so the change never lands in the high phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst || start_det || stop_det)
			hold_q <= 5'h00;
		else if (scl_fall)
			hold_q <= 5'(TDH_CYC);
		else if (hold_q != 5'h00)
			hold_q <= hold_q - 5'h01;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || start_det || stop_det)
			sda_oe_q <= 1'b0;
		else if (hold_q == 5'h01)
			sda_oe_q <= drive_q;
	end

	always_ff @(posedge sys_clk) begin
		sda_o_q <= 1'b0;
	end

	assign sda_val = sda_o_q;
	assign sda_oe  = sda_oe_q;
	assign busy    = busy_q;

	// page buffer; later bytes to the same slot overwrite earlier ones
	always_ff @(posedge sys_clk) begin
		if (wr_out_valid && wr_out_ready) begin
			pbuf_q[wr_out.addr[PAGE_W-1:0]] <= wr_out.data;
			page_q <= wr_out.addr[ADDR_W-1:PAGE_W];
		end
	end

	// stop after write data requests the commit once the buffer drains
	wire commit_go = commit_req_q && !wr_out_valid && !busy_q;
	wire wr_done   = busy_q && (wr_cnt_q == 32'(WR_CYCLES - 1));

	always_ff @(posedge sys_clk) begin
		if (sys_rst || start_det)
			dirty_q <= 1'b0;
		else if (wr_push)
			dirty_q <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			commit_req_q <= 1'b0;
		else if (stop_det && (dirty_q || wr_push))
			commit_req_q <= 1'b1;
		else if (commit_go)
			commit_req_q <= 1'b0;
	end

	// write cycle timer; protected writes never start it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busy_q   <= 1'b0;
			wr_cnt_q <= 32'h0000_0000;
		end else if (commit_go && !wp_s) begin
			busy_q   <= 1'b1;
			wr_cnt_q <= 32'h0000_0000;
		end else if (wr_done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			wr_cnt_q <= wr_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			pvld_q <= '0;
		else if (wr_done || (commit_go && wp_s))
			pvld_q <= '0;
		else if (wr_out_valid && wr_out_ready)
			pvld_q[wr_out.addr[PAGE_W-1:0]] <= 1'b1;
	end

	// array update at the end of the write cycle
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < PAGE_SIZE; i++) begin
			if (wr_done && pvld_q[i])
				mem_q[{page_q, 5'(i)}] <= pbuf_q[i];
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	logic [3:0] busy_len_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !busy_q)
			busy_len_q <= 4'h0;
		else if (busy_len_q != 4'hF)
			busy_len_q <= busy_len_q + 4'h1;
	end

	start_ctrl_a: assert property (start_det |=> state_q == ST_CTRL && bit_cnt_q == BIT_ZERO)
		else $error("start did not return to control byte");
	stop_idle_a: assert property (stop_det |=> state_q == ST_IDLE && !sda_oe_q)
		else $error("stop did not release the bus");
	rise_sample_a: assert property ((scl_rise && !in_ack_q && rx_mode && !start_det && !stop_det)
		|=> shreg_q[0] == $past(sda_s))
		else $error("bit not sampled on clock rise");
	busy_nack_a: assert property (busy_q |-> !ack_q)
		else $error("ack issued during write cycle");
	ack_hold_a: assert property ((sda_oe_q && in_ack_q && scl_s && !stop_det && !start_det) |=> sda_oe_q)
		else $error("ack released during clock high");
	ctrl_match_a: assert property ((byte_done && state_q == ST_CTRL && !ctrl_ok) |=> !ack_q ##1 !drive_q)
		else $error("mismatched control byte acked");
	rw_select_a: assert property ((byte_done && state_q == ST_CTRL && ack_ctrl && is_read) |=> state_q == ST_RDATA)
		else $error("read selector ignored");
	page_wrap_a: assert property (wr_push && !stop_det && !start_det |=> ptr_q[ADDR_W-1:PAGE_W] == $past(ptr_q[ADDR_W-1:PAGE_W])
		&& ptr_q[PAGE_W-1:0] == $past(ptr_q[PAGE_W-1:0]) + 5'h01)
		else $error("pointer left the page");
	stop_commit_a: assert property ((stop_det && dirty_q && !busy_q && !commit_req_q) |=> commit_req_q)
		else $error("stop after data did not request commit");
	busy_len_a: assert property ($rose(busy_q) |-> busy_q [*8])
		else $error("write cycle ended too early");
	busy_min_a: assert property ((busy_q && busy_len_q != 4'hF) |=> busy_q)
		else $error("write cycle shorter than sixteen cycles");

	write_cycle_c: cover property ($rose(busy_q));
	read_byte_c: cover property (tx_end);
	poll_nack_c: cover property (byte_done && state_q == ST_CTRL && ctrl_ok && !idle_ok);
	page_roll_c: cover property (wr_push && ptr_q[PAGE_W-1:0] == 5'h1F);
endmodule
`default_nettype wire

/* File: pkg/ee_pkg.sv */
// constants, field layouts and carrier types for the serial eeprom slave
// assumes a single 40 MHz system clock that samples the two-wire bus pins
package ee_pkg;

	// array geometry
	localparam int ADDR_W     = 12;
	localparam int PAGE_W     = 5;
	localparam int PAGE_SIZE  = 32;
	localparam int MEM_DEPTH  = 4096;
	localparam int BYTE_BITS  = 8;

	// control byte layout
	localparam int CTRL_RW_BIT  = 0;
	localparam int CTRL_CS_LSB  = 1;
	localparam int CTRL_CS_MSB  = 3;
	localparam int CTRL_ID_LSB  = 4;
	localparam int CTRL_ID_MSB  = 7;
	localparam int ADDR_HI_BITS = 4;

	// bit counter values
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;

	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int TWR_NS        = 5_000_000;
	localparam int TWR_CYC       = TWR_NS / CLK_PERIOD_NS;
	localparam int TDH_NS        = 300;
	localparam int TDH_CYC       = (TDH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADRH,
		ST_ADRL,
		ST_WDATA,
		ST_RDATA,
		ST_SKIP
	} ee_state_e;

	// one received write byte with its target address
	typedef struct packed {
		logic [ADDR_W-1:0]    addr;
		logic [BYTE_BITS-1:0] data;
	} ee_wr_s;

endpackage

/* File: verilog/ee_fifo2.sv */
// two-entry valid/ready buffer
// assumes both sides on the same clock; no word is lost while the drain stalls
`timescale 1ns/1ps
`default_nettype none
module ee_fifo2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] slot_q [2];
	logic         wr_ptr_q;
	logic         rd_ptr_q;
	logic [1:0]   count_q;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data  = slot_q[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push)
			slot_q[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_q <= !wr_ptr_q;
			if (pop)
				rd_ptr_q <= !rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

/* File: sim/ee_master_model.sv */
// behavioural two-wire bus master that drives scl and resolves the open-drain sda wire
// assumes the device pulls sda low while sda_oe is high; sda idles high through a pull-up
`timescale 1ns/1ps
`default_nettype none
module ee_master_model (
	// system clock paces the bus
	input  wire logic sys_clk,
	// device side of the data wire
	input  wire logic sda_oe,
	input  wire logic sda_o,
	// bus lines
	output logic      scl,
	output logic      sda
);
	logic m_low;
	// wired-and with pull-up: released line reads high
	assign sda = !(m_low || (sda_oe && !sda_o));
	initial begin
		scl = 1'b1;
		m_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// waits a full low phase first so a device ack is gone before sda rises
	task automatic start();
		wt(20);
		m_low = 1'b0;
		wt(10);
		scl = 1'b1;
		wt(10);
		m_low = 1'b1;
		wt(10);
		scl = 1'b0;
	endtask
	task automatic stop();
		wt(2);
		m_low = 1'b1;
		wt(18);
		scl = 1'b1;
		wt(10);
		m_low = 1'b0;
		wt(20);
	endtask
	// 1 us bit: sda set early in the low phase, held through high, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		wt(2);
		m_low = !b;
		wt(18);
		scl = 1'b1;
		wt(10);
		s = sda;
		wt(10);
		scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!more, s);
	endtask
endmodule
`default_nettype wire

/* File: sim/ee_slave_bench.sv */
// self-checking bench for the serial eeprom slave, one task per scenario
// assumes the master model paces the bus at a 1 us bit so the slave's 300 ns hold fits
`timescale 1ns/1ps
`default_nettype none
module ee_slave_bench;
	import ee_pkg::*;
	localparam int         WRC = 2000;
	localparam logic [3:0] TC  = 4'h6; // arbitrary device-type value
	localparam logic [2:0] CS  = 3'h5;
	logic       sys_clk;
	logic       sys_rst;
	logic       wp_in;
	logic [2:0] cs_pins;
	logic       busy;
	logic       sda_o;
	logic       sda_oe;
	logic       scl;
	logic       sda;
	logic       ack;
	logic [7:0] d;
	int         n_fail;
	int         n_tests;
	ee_slave #(.WR_CYCLES(WRC), .TYPE_CODE(TC)) ee_slave_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_line(scl), .sda_line(sda), .sda_val(sda_o),
		.sda_oe(sda_oe), .write_protect(wp_in), .chip_select_pin_low(cs_pins[0]),
		.chip_select_pin_mid(cs_pins[1]), .chip_select_pin_high(cs_pins[2]), .busy(busy));
	ee_master_model ee_master_model_i (.sys_clk(sys_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	function automatic logic [7:0] ctl(input logic rw);
		return {TC, CS, rw};
	endfunction
	task automatic wait_idle();
		int k;
		for (k = 0; k < WRC + 100 && busy !== 1'b0; k++) @(negedge sys_clk);
		if (k >= WRC + 100) begin
			$display("ERROR busy expected 0 seen %b", busy);
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic set_addr(input logic [11:0] a);
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b0), ack);
		chk_b("ctrl ack", 1'b1, ack);
		ee_master_model_i.wbyte({4'h0, a[11:8]}, ack);
		chk_b("adrh ack", 1'b1, ack);
		ee_master_model_i.wbyte(a[7:0], ack);
		chk_b("adrl ack", 1'b1, ack);
	endtask
	task automatic wr_page(input logic [11:0] a, input int n, input logic [7:0] v);
		set_addr(a);
		for (int i = 0; i < n; i++) begin
			ee_master_model_i.wbyte(v + 8'(i), ack);
			chk_b("data ack", 1'b1, ack);
		end
		ee_master_model_i.stop();
		chk_b("busy", 1'b1, busy);
		wait_idle();
	endtask
	// random read: restart after the address bytes, then read control
	task automatic rd_at(input logic [11:0] a, input logic more);
		set_addr(a);
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b1), ack);
		chk_b("rd ack", 1'b1, ack);
		ee_master_model_i.rbyte(more, d);
	endtask
	task automatic sc_select();
		for (int i = 0; i < 4; i++) begin
			ee_master_model_i.start();
			ee_master_model_i.wbyte(ctl(1'b0) ^ (8'h02 << i), ack);
			chk_b("bad ctrl ack", 1'b0, ack);
			ee_master_model_i.stop();
		end
	endtask
	task automatic sc_byte_poll();
		set_addr(12'h000);
		ee_master_model_i.wbyte(8'h3C, ack);
		chk_b("data ack", 1'b1, ack);
		ee_master_model_i.stop();
		chk_b("busy", 1'b1, busy);
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b0), ack);
		chk_b("poll busy", 1'b0, ack);
		ee_master_model_i.stop();
		wait_idle();
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b0), ack);
		chk_b("poll idle", 1'b1, ack);
		ee_master_model_i.stop();
		rd_at(12'h000, 1'b0);
		ee_master_model_i.stop();
		chk("rd 000", 8'h3C, d);
	endtask
	task automatic sc_wrap_read();
		wr_page(12'hFFF, 1, 8'hA5);
		rd_at(12'hFFF, 1'b1);
		chk("rd FFF", 8'hA5, d);
		ee_master_model_i.rbyte(1'b0, d);
		ee_master_model_i.stop();
		chk("rd wrap", 8'h3C, d);
	endtask
	// 33 bytes from offset 30: crosses the page end and the last overwrites the first
	task automatic sc_page();
		logic [7:0] e;
		wr_page(12'h03E, 33, 8'h40);
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b1), ack);
		ee_master_model_i.rbyte(1'b0, d);
		ee_master_model_i.stop();
		chk("cur rd", 8'h41, d);
		rd_at(12'h020, 1'b1);
		for (int o = 0; o < 32; o++) begin
			e = (o == 30) ? 8'h60 : 8'h40 + 8'((o + 2) % 32);
			if (o > 0) ee_master_model_i.rbyte(o < 31, d);
			chk("page", e, d);
		end
		ee_master_model_i.stop();
	endtask
	task automatic sc_protect();
		wp_in = 1'b1;
		set_addr(12'hFFF);
		ee_master_model_i.wbyte(8'h99, ack);
		chk_b("wp data ack", 1'b1, ack);
		ee_master_model_i.stop();
		chk_b("wp busy", 1'b0, busy);
		rd_at(12'hFFF, 1'b0);
		ee_master_model_i.stop();
		chk("wp rd", 8'hA5, d);
		wp_in = 1'b0;
	endtask
	task automatic sc_abort();
		ee_master_model_i.start();
		for (int i = 0; i < 4; i++) ee_master_model_i.bit_io(i[0], ack);
		ee_master_model_i.start();
		ee_master_model_i.wbyte(ctl(1'b1), ack);
		chk_b("ack after abort", 1'b1, ack);
		ee_master_model_i.rbyte(1'b0, d);
		ee_master_model_i.stop();
		chk("rd after abort", 8'h3C, d);
	endtask
	initial begin
		sys_rst = 1'b1;
		wp_in = 1'b0;
		cs_pins = CS;
		n_fail = 0;
		n_tests = 0;
		repeat (20) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk_b("reset oe", 1'b0, sda_oe);
		chk_b("reset busy", 1'b0, busy);
		chk_b("reset sda_o", 1'b0, sda_o);
		sc_select();
		sc_byte_poll();
		sc_wrap_read();
		sc_page();
		sc_protect();
		sc_abort();
		tally_and_finish();
	end
endmodule
`default_nettype wire
